// ---- design/term_status_pkg.sv ----
// constants for the terminal status low byte and its register window
`default_nettype none
package term_status_pkg;
  // wishbone byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_BITWORD = 8'h04;
  localparam logic [7:0] OFF_PEND = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  // status byte field positions
  localparam int MON_MIP_BIT = 7;
  localparam int RT_MIP_BIT = 4;
  localparam int RT_INH_BIT = 2;
  localparam int CKS_ERR_BIT = 1;
  localparam int RAM_FAIL_BIT = 0;
  // pending and mask field positions
  localparam int PEND_CKS_BIT = 14;
  localparam int PEND_RAM_BIT = 13;
  // built-in test word: which bus was shut down
  localparam int BITW_BUS_A_BIT = 0;
  localparam int BITW_BUS_B_BIT = 1;
  // reset values
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] BITWORD_RST = 16'h0000;
  localparam logic [15:0] PEND_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
endpackage
`default_nettype wire

// ---- design/terminal_status_low_bits.sv ----
// low byte of the terminal master status word with init-failure interrupts
// How it works
// R1 - monitor in-progress bit 7 sets on valid command, clears at message end
// R2 - RT in-progress bit 4 sets on command for the RT, clears at end
// R3 - bits 6, 5 and 3 of the status byte always read zero
// R4 - bit 2 high while one bus is inhibited by a shutdown mode code
// R5 - inhibit ends on override mode code, master reset or RT soft reset request
// R6 - the shut-down bus is recorded in the built-in test word
// R7 - checksum failure sets bit 1 and pending bit 14
// R8 - init failure flags work only if auto-init strap was high at reset release
// R9 - failures are caught in full auto-init and in terminal soft-reset reloads
// R10 - RAM mismatch sets bit 0 and pending bit 13
// R11 - while not ready, every read returns the status register
// R12 - status flags are read-only and clear on master reset
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`default_nettype none
module terminal_status_low_bits (
  // clock and master reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // strap and readiness
  input wire logic auto_init_enable_pin_i,
  input wire logic ready_i,
  // protocol events
  input wire logic mon_cmd_valid_i,
  input wire logic mon_msg_done_i,
  input wire logic rt_cmd_valid_i,
  input wire logic rt_msg_done_i,
  input wire logic bus_shutdown_i,
  input wire logic bus_shutdown_sel_b_i,
  input wire logic shutdown_override_i,
  input wire logic rt_soft_reset_request_i,
  input wire logic monitor_soft_reset_request_i,
  // auto-initialization results
  input wire logic init_busy_i,
  input wire logic checksum_fail_i,
  input wire logic ram_mismatch_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt and status
  output logic irq_o,
  output logic rt_bus_inhibited_o
);

  logic mon_mip_r, mon_mip_nxt;
  logic rt_mip_r, rt_mip_nxt;
  logic inh_r, inh_nxt;
  logic cks_r, cks_nxt;
  logic ram_r, ram_nxt;
  logic auto_en_r, auto_en_nxt;
  logic strap_done_r, strap_done_nxt;
  logic reload_r, reload_nxt;
  logic [15:0] bitw_r, bitw_nxt;
  logic [15:0] pend_r, pend_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic irq_r, irq_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [15:0] status_w;
  logic req_w, wr_w, cks_evt_w, ram_evt_w, win_w;

  // set has priority so an event in the clearing cycle survives
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction

  // unused bits stay tied low in the assembled word
  always_comb begin
    status_w = term_status_pkg::STATUS_RST; // R3
    status_w[term_status_pkg::MON_MIP_BIT] = mon_mip_r;
    status_w[term_status_pkg::RT_MIP_BIT] = rt_mip_r;
    status_w[term_status_pkg::RT_INH_BIT] = inh_r;
    status_w[term_status_pkg::CKS_ERR_BIT] = cks_r;
    status_w[term_status_pkg::RAM_FAIL_BIT] = ram_r;
  end

  // a request is taken once; ack drops the cycle after
  assign req_w = wb_cyc_i & wb_stb_i & ~ack_r;
  // host writes are locked out while not ready
  assign wr_w = req_w & wb_we_i & ready_i;
  // failures count only inside an init or reload with the strap captured
  assign win_w = auto_en_r & (init_busy_i | reload_r); // R8 R9
  assign cks_evt_w = checksum_fail_i & win_w; // R7
  assign ram_evt_w = ram_mismatch_i & win_w; // R10

  // flag, strap and interrupt state
  always_comb begin
    strap_done_nxt = 1'b1;
    // strap is caught at the first edge after release, not under reset
    auto_en_nxt = strap_done_r ? auto_en_r : auto_init_enable_pin_i; // R8
    // a reload window spans a soft reset request until init busy drops
    reload_nxt = reload_r;
    if (rt_soft_reset_request_i | monitor_soft_reset_request_i) begin // R9
      reload_nxt = 1'b1;
    end else if (!init_busy_i) begin
      reload_nxt = 1'b0;
    end
    // message flags: a set in the ending cycle wins
    mon_mip_nxt = flag_next(mon_mip_r, mon_cmd_valid_i, mon_msg_done_i); // R1
    rt_mip_nxt = flag_next(rt_mip_r, rt_cmd_valid_i, rt_msg_done_i); // R2
    inh_nxt = flag_next(inh_r, bus_shutdown_i,
                        shutdown_override_i | rt_soft_reset_request_i); // R4 R5
    cks_nxt = cks_r | cks_evt_w; // R7
    ram_nxt = ram_r | ram_evt_w; // R10
    // last shutdown overwrites, only one bus is ever inhibited at a time
    bitw_nxt = bitw_r;
    if (bus_shutdown_i) begin // R6
      bitw_nxt = term_status_pkg::BITWORD_RST;
      if (bus_shutdown_sel_b_i) begin
        bitw_nxt[term_status_pkg::BITW_BUS_B_BIT] = 1'b1;
      end else begin
        bitw_nxt[term_status_pkg::BITW_BUS_A_BIT] = 1'b1;
      end
    end
    // write-one clears first, events set on top so a clash keeps the bit
    pend_nxt = pend_r;
    mask_nxt = mask_r;
    if (wr_w && wb_adr_i == term_status_pkg::OFF_PEND && wb_sel_i[1]) begin
      pend_nxt[15:8] = pend_r[15:8] & ~wb_dat_i[15:8];
    end
    if (wr_w && wb_adr_i == term_status_pkg::OFF_MASK && wb_sel_i[1]) begin
      mask_nxt[term_status_pkg::PEND_CKS_BIT] = wb_dat_i[term_status_pkg::PEND_CKS_BIT];
      mask_nxt[term_status_pkg::PEND_RAM_BIT] = wb_dat_i[term_status_pkg::PEND_RAM_BIT];
    end
    pend_nxt[term_status_pkg::PEND_CKS_BIT] =
      cks_evt_w | pend_nxt[term_status_pkg::PEND_CKS_BIT]; // R7
    pend_nxt[term_status_pkg::PEND_RAM_BIT] =
      ram_evt_w | pend_nxt[term_status_pkg::PEND_RAM_BIT]; // R10
    // from the next values so irq moves on the same edge as pending
    irq_nxt = |(pend_nxt & mask_nxt);
  end

  // master reset clears every flag
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin // R12
      mon_mip_r <= 1'b0;
      rt_mip_r <= 1'b0;
      inh_r <= 1'b0; // R5
      cks_r <= 1'b0;
      ram_r <= 1'b0;
      auto_en_r <= 1'b0;
      strap_done_r <= 1'b0;
      reload_r <= 1'b0;
      bitw_r <= term_status_pkg::BITWORD_RST;
      pend_r <= term_status_pkg::PEND_RST;
      mask_r <= term_status_pkg::MASK_RST;
      irq_r <= 1'b0;
    end else begin
      mon_mip_r <= mon_mip_nxt;
      rt_mip_r <= rt_mip_nxt;
      inh_r <= inh_nxt;
      cks_r <= cks_nxt;
      ram_r <= ram_nxt;
      auto_en_r <= auto_en_nxt;
      strap_done_r <= strap_done_nxt;
      reload_r <= reload_nxt;
      bitw_r <= bitw_nxt;
      pend_r <= pend_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  // bus answer: one cycle after the request, data registered with ack
  always_comb begin
    ack_nxt = req_w;
    dat_nxt = 32'h0000_0000;
    if (req_w && !wb_we_i) begin
      if (!ready_i) begin
        dat_nxt[15:0] = status_w; // R11
      end else begin
        unique case (wb_adr_i)
          term_status_pkg::OFF_STATUS: dat_nxt[15:0] = status_w;
          term_status_pkg::OFF_BITWORD: dat_nxt[15:0] = bitw_r;
          term_status_pkg::OFF_PEND: dat_nxt[15:0] = pend_r;
          term_status_pkg::OFF_MASK: dat_nxt[15:0] = mask_r;
          default: dat_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // status offset has no write path at all
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt; // R12
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq_o = irq_r;
  assign rt_bus_inhibited_o = inh_r;

  // checks share one clock and stay quiet while master reset is held
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // message flags follow their set and clear events
  a_mon_mip_set: assert property (mon_cmd_valid_i |=> mon_mip_r) // R1
    else $error("monitor in-progress not set after command");
  a_mon_mip_clr: assert property (mon_msg_done_i && !mon_cmd_valid_i |=> !mon_mip_r) // R1
    else $error("monitor in-progress not cleared at end");
  a_mon_mip_hold: assert property (mon_mip_r && !mon_msg_done_i |=> mon_mip_r) // R1
    else $error("monitor in-progress dropped before end");
  a_rt_mip_set: assert property (rt_cmd_valid_i |=> rt_mip_r) // R2
    else $error("rt in-progress not set after command");
  a_rt_mip_track: assert property (rt_cmd_valid_i ##1 !rt_msg_done_i |=> rt_mip_r) // R2
    else $error("rt in-progress lost before end");
  a_rt_mip_clr: assert property (rt_msg_done_i && !rt_cmd_valid_i |=> !rt_mip_r) // R2
    else $error("rt in-progress not cleared at end");
  // unused positions of the status byte, on any read that returns it
  a_unused_zero: assert property (req_w && !wb_we_i // R3
                                  && (!ready_i || wb_adr_i == term_status_pkg::OFF_STATUS)
                                  |=> wb_dat_o[6:5] == 2'b00 && !wb_dat_o[3])
    else $error("unused status bits not zero");

  // bus shutdown inhibit and its record in the built-in test word
  a_inh_set: assert property (bus_shutdown_i |=> rt_bus_inhibited_o) // R4
    else $error("inhibit not raised by shutdown");
  a_inh_hold: assert property (inh_r && !shutdown_override_i && !rt_soft_reset_request_i // R4
                               |=> inh_r)
    else $error("inhibit dropped without cause");
  a_inh_end: assert property ((shutdown_override_i || rt_soft_reset_request_i) // R5
                              && !bus_shutdown_i |=> !rt_bus_inhibited_o)
    else $error("inhibit not ended");
  a_bit_word: assert property (bus_shutdown_i && bus_shutdown_sel_b_i // R6
                               |=> bitw_r[term_status_pkg::BITW_BUS_B_BIT])
    else $error("shut-down bus not recorded");
  a_bit_word_a: assert property (bus_shutdown_i && !bus_shutdown_sel_b_i // R6
                                 |=> bitw_r[term_status_pkg::BITW_BUS_A_BIT]
                                 && !bitw_r[term_status_pkg::BITW_BUS_B_BIT])
    else $error("bus a shutdown not recorded");
  a_bit_word_one: assert property ($onehot0(bitw_r)) // R6
    else $error("built-in test word names more than one bus");
  a_bitw_hold: assert property (!bus_shutdown_i |=> $stable(bitw_r)) // R6
    else $error("built-in test word changed with no shutdown");

  // failure flags: set with their pending bit, sticky, gated by strap and window
  a_cks_pend: assert property (cks_evt_w |=> cks_r && pend_r[term_status_pkg::PEND_CKS_BIT]) // R7
    else $error("checksum failure not flagged");
  a_ram_pend: assert property (ram_evt_w |=> ram_r && pend_r[term_status_pkg::PEND_RAM_BIT]) // R10
    else $error("ram mismatch not flagged");
  a_gate_strap: assert property (!auto_en_r |=> $stable(cks_r) && $stable(ram_r)) // R8
    else $error("failure flagged without strap");
  a_strap_hold: assert property (strap_done_r |=> $stable(auto_en_r)) // R8
    else $error("auto-init strap changed after capture");
  a_reload_open: assert property (rt_soft_reset_request_i || monitor_soft_reset_request_i // R9
                                  |=> reload_r)
    else $error("soft reset request did not open the reload window");
  a_win_gate: assert property (!init_busy_i && !reload_r // R9
                               |=> $stable(cks_r) && $stable(ram_r))
    else $error("failure flagged outside an init window");
  a_status_ro: assert property (cks_r |=> cks_r) // R12
    else $error("checksum flag cleared without reset");
  a_ram_sticky: assert property (ram_r |=> ram_r) // R12
    else $error("ram failure flag cleared without reset");

  // pending, mask and interrupt stay coherent
  a_irq_level: assert property (irq_o == |(pend_r & mask_r)) // R7 R10
    else $error("interrupt level disagrees with pending and mask");
  a_pend_bits: assert property (!pend_r[15] && pend_r[12:0] == 13'h0000) // R7 R10
    else $error("pending bit set with no source");
  a_mask_bits: assert property (!mask_r[15] && mask_r[12:0] == 13'h0000) // R7 R10
    else $error("mask bit set outside the failure sources");
  a_pend_clear: assert property (wr_w && wb_adr_i == term_status_pkg::OFF_PEND // R7
                                 && wb_sel_i[1] && wb_dat_i[term_status_pkg::PEND_CKS_BIT]
                                 && !cks_evt_w |=> !pend_r[term_status_pkg::PEND_CKS_BIT])
    else $error("checksum pending not cleared by write of one");
  a_ram_clear: assert property (wr_w && wb_adr_i == term_status_pkg::OFF_PEND // R10
                                && wb_sel_i[1] && wb_dat_i[term_status_pkg::PEND_RAM_BIT]
                                && !ram_evt_w |=> !pend_r[term_status_pkg::PEND_RAM_BIT])
    else $error("ram pending not cleared by write of one");

  // bus answer and the not-ready lockout
  a_ready_alias: assert property (req_w && !wb_we_i && !ready_i // R11
                                  |=> wb_ack_o && wb_dat_o[15:0] == $past(status_w))
    else $error("not-ready read did not return status");
  a_notready_wr: assert property (req_w && wb_we_i && !ready_i |=> $stable(mask_r)) // R11
    else $error("write took effect while not ready");
  a_ack_once: assert property (req_w |=> wb_ack_o ##1 !wb_ack_o) // R11
    else $error("bus answer not a single cycle after the request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) // R11
    else $error("upper half of read data not zero");

  // main scenarios reached by the bench
  c_rt_shutdown: cover property (bus_shutdown_i ##[1:20] shutdown_override_i);
  c_cks_irq: cover property (cks_evt_w ##[1:4] irq_o);
  c_notready_read: cover property (req_w && !ready_i ##1 wb_ack_o);
  c_reload_fail: cover property (reload_r && ram_evt_w);
  c_strap_off: cover property (strap_done_r && !auto_en_r && checksum_fail_i);

endmodule
`default_nettype wire

// ---- sim/wb_host_model.sv ----
// host model: wishbone master issuing classic single cycles
`default_nettype none
module wb_host_model (
  // clock
  input wire logic clk_i,
  // answer from the block
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  // request to the block
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus from time zero
  initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  // one transfer; no cycle limit, the bench watchdog cuts a hang
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hf;
    wb_dat_o <= dat;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i; // taken at the ack edge only
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the terminal status low byte
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, auto_init_enable_pin_i, ready_i, bus_shutdown_sel_b_i, init_busy_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, rt_bus_inhibited_o;
  logic [9:0] ev;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int mismatches, comparisons;
  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // event bits: 0 mon cmd, 1 mon done, 2 rt cmd, 3 rt done, 4 shutdown,
  // 5 override, 6 rt srst, 7 mon srst, 8 checksum fail, 9 ram mismatch
  terminal_status_low_bits dut (.clk_i, .rst_n_i, .auto_init_enable_pin_i, .ready_i,
    .mon_cmd_valid_i(ev[0]), .mon_msg_done_i(ev[1]), .rt_cmd_valid_i(ev[2]),
    .rt_msg_done_i(ev[3]), .bus_shutdown_i(ev[4]), .bus_shutdown_sel_b_i,
    .shutdown_override_i(ev[5]), .rt_soft_reset_request_i(ev[6]),
    .monitor_soft_reset_request_i(ev[7]), .init_busy_i, .checksum_fail_i(ev[8]),
    .ram_mismatch_i(ev[9]), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .rt_bus_inhibited_o);
  wb_host_model host (.clk_i, .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o),
    .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i),
    .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic st(input logic [31:0] e);
    rd(term_status_pkg::OFF_STATUS, e);
  endtask
  task automatic pd(input logic [31:0] e);
    rd(term_status_pkg::OFF_PEND, e);
  endtask
  // one-cycle pulse, then two edges so the registered flags settle
  task automatic pulse(input logic [9:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= '0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk_i);
    auto_init_enable_pin_i <= s;
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset;
    st(32'h0);
    pd(32'h0);
    rd(term_status_pkg::OFF_BITWORD, 32'h0);
    rd(8'h10, 32'h0);
  endtask
  task automatic t_mip;
    pulse(10'h001);
    st(32'h80);
    pulse(10'h004);
    st(32'h90);
    pulse(10'h00b);
    st(32'h80);
    pulse(10'h002);
    st(32'h0);
  endtask
  task automatic t_inh;
    bus_shutdown_sel_b_i <= 1'b1;
    pulse(10'h010);
    chk("inhibit", {31'h0, rt_bus_inhibited_o}, 32'h1);
    st(32'h04);
    rd(term_status_pkg::OFF_BITWORD, 32'h2);
    pulse(10'h020);
    st(32'h0);
    bus_shutdown_sel_b_i <= 1'b0;
    pulse(10'h010);
    rd(term_status_pkg::OFF_BITWORD, 32'h1);
    pulse(10'h040);
    st(32'h0);
    pulse(10'h010); // left inhibited for the master reset later
  endtask
  task automatic t_fail;
    init_busy_i <= 1'b1;
    pulse(10'h100);
    st(32'h06);
    pd(32'h4000);
    chk("irq", {31'h0, irq_o}, 32'h0);
    wr(term_status_pkg::OFF_MASK, 32'h6000);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, irq_o}, 32'h1);
    pulse(10'h200);
    init_busy_i <= 1'b0;
    st(32'h07);
    pd(32'h6000);
    wr(term_status_pkg::OFF_STATUS, 32'hff);
    st(32'h07);
    wr(term_status_pkg::OFF_PEND, 32'h4000);
    pd(32'h2000);
    wr(term_status_pkg::OFF_PEND, 32'h2000);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, irq_o}, 32'h0);
  endtask
  task automatic t_ready;
    ready_i <= 1'b0;
    rd(term_status_pkg::OFF_MASK, 32'h07);
    wr(term_status_pkg::OFF_MASK, 32'h0);
    ready_i <= 1'b1;
    rd(term_status_pkg::OFF_MASK, 32'h6000);
  endtask
  task automatic t_strap;
    do_reset(1'b0);
    chk("inhibit", {31'h0, rt_bus_inhibited_o}, 32'h0);
    st(32'h0);
    init_busy_i <= 1'b1;
    pulse(10'h300);
    init_busy_i <= 1'b0;
    st(32'h0);
    pd(32'h0);
  endtask
  task automatic t_reload;
    do_reset(1'b1);
    wr(term_status_pkg::OFF_MASK, 32'h6000);
    pulse(10'h100); // checksum outside any init window
    st(32'h0);
    init_busy_i <= 1'b1;
    pulse(10'h080);
    pulse(10'h200);
    pulse(10'h040);
    pulse(10'h100);
    init_busy_i <= 1'b0;
    st(32'h03);
    pd(32'h6000);
    chk("irq", {31'h0, irq_o}, 32'h1);
  endtask
  // main sequence
  initial begin
    {rst_n_i, auto_init_enable_pin_i, bus_shutdown_sel_b_i, init_busy_i} = '0;
    ready_i = 1'b1;
    ev = '0;
    mismatches = 0;
    comparisons = 0;
    do_reset(1'b1);
    t_reset;
    t_mip;
    t_inh;
    t_fail;
    t_ready;
    t_strap;
    t_reload;
    test_done;
  end
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    $display("MISMATCH watchdog expected done seen hang");
    test_done;
  end
endmodule
`default_nettype wire
